//--- logic/fns_supervisor.sv
// Fieldbus node supervisor: switch capture, registers, monitoring and fallback
//
// Overview of operation
// [R01] Node address switches read only after power-up
// [R02] Valid node addresses are 1 to 127
// [R03] Address is tens switch 0-12 plus units
// [R04] Invalid address: never answer until repowered
// [R05] Communicate only with valid address and rate
// [R06] Baud selector read only after power-up
// [R07] Selector positions 0-6 map to fixed rates
// [R08] Half duplex: never transmit while receiving
// [R09] Characters use RTU, 8 data, even, 1 stop
// [R10] Config bit 1 picks how fallback ends
// [R11] Halt register stops or restarts internal bus
// [R12] Halted internal bus forces island outputs zero
// [R13] Bad expansion parameter blocks clearing halt register
// [R14] Config bit 0 selects 32-bit word order
// [R15] Config bit 1 selects automatic or manual acknowledge
// [R16] Fault command codes 0, 2, 3 ack/clear
// [R17] Command bits 15:2 ignored, master writes zero
// [R18] Command read bit 0 shows fault present
// [R19] Read-only counter of monitoring faults
// [R20] Monitoring time in ms, zero disables
// [R21] Timeout enters fallback, outputs take fallback values
// [R22] Fallback sets status bit 9; writing 0 clears
// [R23] Each timeout counts once, counter saturates
// [R24] Timer reloads on each good frame, 1 ms ticks
`timescale 1ns/1ps
`default_nettype none
module fns_supervisor
	import fns_pkg::*;
#(
	parameter int MS_CYCLES = FNS_MS_CYCLES
) (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	// Rotary switches
	input  wire logic [3:0]  addr_tens_i,
	input  wire logic [3:0]  addr_units_i,
	input  wire logic [3:0]  baud_pos_i,
	// Register requests from the frame layer
	input  wire logic        req_valid_i,
	input  wire logic        req_write_i,
	input  wire logic [7:0]  req_node_i,
	input  wire logic [15:0] req_addr_i,
	input  wire logic [15:0] req_wdata_i,
	input  wire logic        frame_ok_i,
	// Register answers
	output logic             rsp_valid_o,
	output logic             rsp_error_o,
	output logic [15:0]      rsp_rdata_o,
	// Line direction
	input  wire logic        tx_busy_i,
	output logic             link_tx_en_o,
	output logic             link_rx_en_o,
	// Link settings
	output logic [7:0]       node_addr_o,
	output logic             node_valid_o,
	output logic [15:0]      baud_rate_o,
	output logic             comm_enable_o,
	output logic [3:0]       frame_data_bits_o,
	output logic             frame_parity_even_o,
	output logic [1:0]       frame_stop_bits_o,
	// Island side
	input  wire logic        exp_param_bad_i,
	input  wire logic [15:0] island_out_i,
	input  wire logic [15:0] fallback_val_i,
	output logic [15:0]      island_out_o,
	output logic             int_bus_run_o,
	output logic             word_swap_o,
	output logic             fallback_o,
	output logic             fault_present_o
);

	// ------------------------------------------------------------------
	// Decoding functions
	// ------------------------------------------------------------------
	// [R07] selector to rate
	function automatic logic [15:0] baud_of(input logic [3:0] pos);
		logic [15:0] rate;
		unique case (pos)
			4'h0:    rate = FNS_BAUD_19200;
			4'h1:    rate = FNS_BAUD_1200;
			4'h2:    rate = FNS_BAUD_2400;
			4'h3:    rate = FNS_BAUD_4800;
			4'h4:    rate = FNS_BAUD_9600;
			4'h5:    rate = FNS_BAUD_19200;
			4'h6:    rate = FNS_BAUD_38400;
			default: rate = 16'h0000; // Positions 7-15 have no rate
		endcase
		return rate;
	endfunction

	// [R03] two decimal digits
	function automatic logic [7:0] addr_of(input logic [3:0] tens, input logic [3:0] units);
		logic [7:0] prod;
		prod = 8'(tens * FNS_TENS_WT);
		return prod + {4'h0, units};
	endfunction

	// ------------------------------------------------------------------
	// Switch synchronisers
	// ------------------------------------------------------------------
	logic [11:0] sw_meta;
	logic [11:0] sw_sync;

	// Two flops on every switch line
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sw_meta <= 12'h000;
			sw_sync <= 12'h000;
		end else begin
			sw_meta <= {baud_pos_i, addr_tens_i, addr_units_i};
			sw_sync <= sw_meta;
		end
	end

	// ------------------------------------------------------------------
	// Power-up capture and mode
	// ------------------------------------------------------------------
	fns_mode_type mode;
	fns_mode_type next_mode;
	logic [1:0]   settle;
	logic [1:0]   next_settle;
	logic [7:0]   node_addr;
	logic [7:0]   next_node_addr;
	logic [15:0]  baud_rate;
	logic [15:0]  next_baud_rate;
	logic         node_valid;
	logic         next_node_valid;
	logic [7:0]   sw_addr;
	logic         sw_addr_ok;

	// Registers and state of the fault logic, declared early for the mode logic
	logic         halt;
	logic         next_halt;
	logic [15:0]  tmo_ms;
	logic [15:0]  next_tmo_ms;
	logic [1:0]   cfg;
	logic [1:0]   next_cfg;
	logic [15:0]  fault_cnt;
	logic [15:0]  next_fault_cnt;
	logic         fault;
	logic         next_fault;
	logic         accept;
	logic         wr_cmd;
	logic         fb_exit;

	fns_mon_if mon ();

	assign sw_addr = addr_of(sw_sync[7:4], sw_sync[3:0]);
	// [R02] address range check
	assign sw_addr_ok = (sw_sync[7:4] <= FNS_TENS_MAX) && (sw_sync[3:0] <= FNS_UNITS_MAX)
		&& (sw_addr >= FNS_NODE_MIN) && (sw_addr <= FNS_NODE_MAX);

	// Next mode and captured switch values
	always_comb begin
		next_mode       = mode;
		next_settle     = settle;
		next_node_addr  = node_addr;
		next_baud_rate  = baud_rate;
		next_node_valid = node_valid;
		unique case (mode)
			FNS_MODE_WAIT: begin
				if (settle == FNS_SETTLE_CYCLES) begin
					// [R01] capture once after power-up
					next_node_addr  = sw_addr;
					next_node_valid = sw_addr_ok;
					// [R06] rate fixed until repower
					next_baud_rate  = baud_of(sw_sync[11:8]);
					// [R04] invalid address locks silent
					next_mode = (sw_addr_ok && baud_of(sw_sync[11:8]) != 16'h0000)
						? FNS_MODE_RUN : FNS_MODE_DEAD;
				end else begin
					next_settle = settle + 2'h1;
				end
			end
			FNS_MODE_DEAD: begin
				next_mode = FNS_MODE_DEAD;
			end
			FNS_MODE_RUN: begin
				// [R21] timeout enters fallback
				if (mon.expired) begin
					next_mode = FNS_MODE_FALLBACK;
				end
			end
			FNS_MODE_FALLBACK: begin
				// [R10] exit condition, timeout wins
				if (fb_exit && !mon.expired) begin
					next_mode = FNS_MODE_RUN;
				end
			end
		endcase
	end

	// Mode and capture registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode       <= FNS_MODE_WAIT;
			settle     <= 2'h0;
			node_addr  <= 8'h00;
			baud_rate  <= 16'h0000;
			node_valid <= 1'b0;
		end else begin
			mode       <= next_mode;
			settle     <= next_settle;
			node_addr  <= next_node_addr;
			baud_rate  <= next_baud_rate;
			node_valid <= next_node_valid;
		end
	end

	// ------------------------------------------------------------------
	// Request acceptance
	// ------------------------------------------------------------------
	// [R05] talk only when address and rate usable
	assign comm_enable_o = (mode == FNS_MODE_RUN) || (mode == FNS_MODE_FALLBACK);
	assign accept        = req_valid_i && comm_enable_o && (req_node_i == node_addr);
	assign wr_cmd        = accept && req_write_i && (req_addr_i == FNS_CMD_ADDR);
	// [R10] exit on any request, or on command write with bit 0 clear
	assign fb_exit = cfg[FNS_CFG_ACK_BIT] ? (wr_cmd && !req_wdata_i[FNS_CMD_FAULT_BIT]) : accept;

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// Next register values
	always_comb begin
		next_halt      = halt;
		next_tmo_ms    = tmo_ms;
		next_cfg       = cfg;
		next_fault_cnt = fault_cnt;
		next_fault     = fault;
		if (accept && req_write_i) begin
			unique case (req_addr_i)
				FNS_HALT_ADDR: begin
					// [R11] halt or restart
					if (req_wdata_i[FNS_HALT_BIT]) begin
						next_halt = 1'b1;
					// [R13] refuse clear on bad parameter
					end else if (!exp_param_bad_i) begin
						next_halt = 1'b0;
					end
				end
				FNS_TMO_ADDR: next_tmo_ms = req_wdata_i;
				FNS_CFG_ADDR: next_cfg = req_wdata_i[1:0];
				FNS_CMD_ADDR: begin
					// [R16] decode bits 1:0 only
					// [R17] upper bits ignored
					if (req_wdata_i[1:0] == FNS_CMD_ACK_KEEP ||
						req_wdata_i[1:0] == FNS_CMD_ACK_CLEAR) begin
						next_fault = 1'b0;
					end
					if (req_wdata_i[1:0] == FNS_CMD_ACK_CLEAR ||
						req_wdata_i[1:0] == FNS_CMD_CLEAR) begin
						next_fault_cnt = FNS_CNT_RESET;
					end
				end
				default: ;
			endcase
		end
		// [R15] automatic mode clears fault when fallback ends
		if (!cfg[FNS_CFG_ACK_BIT] && mode == FNS_MODE_FALLBACK && fb_exit) begin
			next_fault = 1'b0;
		end
		// [R23] timeout counts and flags, set wins
		if (mon.expired) begin
			next_fault = 1'b1;
			if (next_fault_cnt != FNS_CNT_MAX) begin
				next_fault_cnt = next_fault_cnt + 16'h0001;
			end
		end
	end

	// Register file
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			halt      <= FNS_HALT_RESET;
			tmo_ms    <= FNS_TMO_RESET;
			cfg       <= FNS_CFG_RESET;
			fault_cnt <= FNS_CNT_RESET;
			fault     <= 1'b0;
		end else begin
			halt      <= next_halt;
			tmo_ms    <= next_tmo_ms;
			cfg       <= next_cfg;
			fault_cnt <= next_fault_cnt;
			fault     <= next_fault;
		end
	end

	// ------------------------------------------------------------------
	// Read answers
	// ------------------------------------------------------------------
	logic        next_rsp_valid;
	logic        next_rsp_error;
	logic [15:0] next_rsp_rdata;

	// Read mux and error for unmapped or read-only writes
	always_comb begin
		next_rsp_valid = accept;
		next_rsp_error = 1'b0;
		next_rsp_rdata = 16'h0000;
		if (accept) begin
			unique case (req_addr_i)
				FNS_STATUS_ADDR: begin
					next_rsp_rdata[FNS_STAT_FALLBACK_BIT] = (mode == FNS_MODE_FALLBACK);
					next_rsp_error = req_write_i;
				end
				FNS_HALT_ADDR: next_rsp_rdata[FNS_HALT_BIT] = halt;
				FNS_TMO_ADDR:  next_rsp_rdata = tmo_ms;
				// [R18] fault present in bit 0
				FNS_CMD_ADDR:  next_rsp_rdata[FNS_CMD_FAULT_BIT] = fault;
				FNS_CFG_ADDR:  next_rsp_rdata[1:0] = cfg;
				FNS_CNT_ADDR: begin
					// [R19] counter is read-only
					next_rsp_rdata = fault_cnt;
					next_rsp_error = req_write_i;
				end
				default: next_rsp_error = 1'b1;
			endcase
		end
	end

	// Answer registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rsp_valid_o <= 1'b0;
			rsp_error_o <= 1'b0;
			rsp_rdata_o <= 16'h0000;
		end else begin
			rsp_valid_o <= next_rsp_valid;
			rsp_error_o <= next_rsp_error;
			rsp_rdata_o <= next_rsp_rdata;
		end
	end

	// ------------------------------------------------------------------
	// Monitoring timer
	// ------------------------------------------------------------------
	// [R24] reload on good frame, new time or fallback exit
	assign mon.restart = comm_enable_o && (next_mode == FNS_MODE_RUN) &&
		(frame_ok_i || fb_exit || (accept && req_write_i && req_addr_i == FNS_TMO_ADDR));
	assign mon.limit_ms = next_tmo_ms;

	fns_mon_timer #(
		.MS_CYCLES (MS_CYCLES)
	) u_timer (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.mon       (mon.timer)
	);

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// [R08] one direction at a time
	assign link_tx_en_o = comm_enable_o && tx_busy_i;
	assign link_rx_en_o = comm_enable_o && !tx_busy_i;
	// [R09] fixed character format
	assign frame_data_bits_o   = FNS_DATA_BITS;
	assign frame_parity_even_o = FNS_PARITY_EVEN;
	assign frame_stop_bits_o   = FNS_STOP_BITS;
	assign node_addr_o   = node_addr;
	assign node_valid_o  = node_valid;
	assign baud_rate_o   = baud_rate;
	// [R12] halted bus drives zero, else fallback values in fallback mode
	assign island_out_o  = halt ? 16'h0000 :
		((mode == FNS_MODE_FALLBACK) ? fallback_val_i : island_out_i);
	assign int_bus_run_o = !halt;
	// [R14] word order select
	assign word_swap_o     = cfg[FNS_CFG_SWAP_BIT];
	// [R22] fallback status
	assign fallback_o      = (mode == FNS_MODE_FALLBACK);
	assign fault_present_o = fault;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_timeout;
		mon.expired && mode == FNS_MODE_RUN;
	endsequence
	sequence s_in_fallback;
		fallback_o && fault;
	endsequence

	timeout_fallback_a: assert property ( // [R21]
		s_timeout |=> s_in_fallback)
		else $error("timeout did not enter fallback");
	dead_is_silent_a: assert property ( // [R04]
		(mode == FNS_MODE_DEAD) |-> (!rsp_valid_o && !comm_enable_o))
		else $error("invalid address node answered");
	strap_stable_a: assert property ( // [R01]
		(mode != FNS_MODE_WAIT) |=> $stable(node_addr) && $stable(baud_rate))
		else $error("captured switches changed after power-up");
	halt_zero_out_a: assert property ( // [R12]
		halt |-> (island_out_o == 16'h0000))
		else $error("outputs not zero while halted");
	halt_refuse_a: assert property ( // [R13]
		(halt && exp_param_bad_i && accept && req_write_i && req_addr_i == FNS_HALT_ADDR)
		|=> halt)
		else $error("halt cleared despite bad parameter");
	count_step_a: assert property ( // [R23]
		(mon.expired && !wr_cmd && fault_cnt != FNS_CNT_MAX)
		|=> (fault_cnt == $past(fault_cnt) + 16'h0001))
		else $error("fault counter did not step on timeout");
	count_clear_a: assert property ( // [R16]
		(wr_cmd && req_wdata_i[1] && !mon.expired) |=> (fault_cnt == 16'h0000))
		else $error("fault counter not cleared by command");
	auto_exit_a: assert property ( // [R10]
		(fallback_o && !cfg[FNS_CFG_ACK_BIT] && accept && !mon.expired)
		|=> (!fallback_o && !fault))
		else $error("fallback did not end on request");
	half_duplex_a: assert property ( // [R08]
		!(link_tx_en_o && link_rx_en_o))
		else $error("transmit and receive enabled together");
	answer_next_a: assert property ( // [R05]
		accept |=> rsp_valid_o)
		else $error("accepted request got no answer");
endmodule
`default_nettype wire

//--- common/fns_pkg.sv
// Constants and types shared by the fieldbus node supervisor files
package fns_pkg;

	// ------------------------------------------------------------------
	// Register addresses on the fieldbus
	// ------------------------------------------------------------------
	localparam logic [15:0] FNS_STATUS_ADDR = 16'h0384;
	localparam logic [15:0] FNS_HALT_ADDR   = 16'h03ed;
	localparam logic [15:0] FNS_TMO_ADDR    = 16'h03ee;
	localparam logic [15:0] FNS_CMD_ADDR    = 16'h03ef;
	localparam logic [15:0] FNS_CFG_ADDR    = 16'h03f0;
	localparam logic [15:0] FNS_CNT_ADDR    = 16'h03f1;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int          FNS_STAT_FALLBACK_BIT = 9;
	localparam int          FNS_CFG_SWAP_BIT      = 0;
	localparam int          FNS_CFG_ACK_BIT       = 1;
	localparam int          FNS_CMD_FAULT_BIT     = 0;
	localparam int          FNS_HALT_BIT          = 0;
	localparam logic [15:0] FNS_TMO_RESET         = 16'h0000;
	localparam logic [1:0]  FNS_CFG_RESET         = 2'h0;
	localparam logic        FNS_HALT_RESET        = 1'b0;
	localparam logic [15:0] FNS_CNT_RESET         = 16'h0000;
	localparam logic [15:0] FNS_CNT_MAX           = 16'hffff;

	// Fault command codes in bits 1:0
	localparam logic [1:0]  FNS_CMD_ACK_KEEP  = 2'h0;
	localparam logic [1:0]  FNS_CMD_ACK_CLEAR = 2'h2;
	localparam logic [1:0]  FNS_CMD_CLEAR     = 2'h3;

	// ------------------------------------------------------------------
	// Node address switches
	// ------------------------------------------------------------------
	localparam logic [7:0]  FNS_NODE_MIN  = 8'h01;
	localparam logic [7:0]  FNS_NODE_MAX  = 8'h7f;
	localparam logic [3:0]  FNS_TENS_MAX  = 4'hc;
	localparam logic [3:0]  FNS_UNITS_MAX = 4'h9;
	localparam logic [7:0]  FNS_TENS_WT   = 8'h0a;

	// ------------------------------------------------------------------
	// Baud rates in bits per second
	// ------------------------------------------------------------------
	localparam logic [15:0] FNS_BAUD_1200  = 16'h04b0;
	localparam logic [15:0] FNS_BAUD_2400  = 16'h0960;
	localparam logic [15:0] FNS_BAUD_4800  = 16'h12c0;
	localparam logic [15:0] FNS_BAUD_9600  = 16'h2580;
	localparam logic [15:0] FNS_BAUD_19200 = 16'h4b00;
	localparam logic [15:0] FNS_BAUD_38400 = 16'h9600;

	// Character format: 8 data bits, even parity, 1 stop bit
	localparam logic [3:0]  FNS_DATA_BITS   = 4'h8;
	localparam logic        FNS_PARITY_EVEN = 1'b1;
	localparam logic [1:0]  FNS_STOP_BITS   = 2'h1;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int          FNS_CLK_PERIOD_PS = 8000;
	localparam int          FNS_TICK_MS       = 1;
	localparam int          FNS_MS_CYCLES     = (FNS_TICK_MS * 1000000000) / FNS_CLK_PERIOD_PS;
	localparam logic [1:0]  FNS_SETTLE_CYCLES = 2'h3;

	// Supervisor operating modes
	typedef enum logic [1:0] {
		FNS_MODE_WAIT,
		FNS_MODE_DEAD,
		FNS_MODE_RUN,
		FNS_MODE_FALLBACK
	} fns_mode_type;

endpackage

//--- common/fns_mon_if.sv
// Link between the supervisor and its millisecond monitoring timer
`timescale 1ns/1ps
`default_nettype none
interface fns_mon_if;
	logic        restart;  // Reload the timer from limit_ms
	logic [15:0] limit_ms; // Monitoring time, 0 disables
	logic        expired;  // One-cycle pulse on timeout
	logic        armed;    // Timer is counting

	modport sup (
		output restart,
		output limit_ms,
		input  expired,
		input  armed
	);
	modport timer (
		input  restart,
		input  limit_ms,
		output expired,
		output armed
	);
endinterface
`default_nettype wire

//--- logic/fns_mon_timer.sv
// Network monitoring timer counting in one-millisecond ticks
`timescale 1ns/1ps
`default_nettype none
module fns_mon_timer
	import fns_pkg::*;
#(
	parameter int MS_CYCLES = FNS_MS_CYCLES
) (
	// Clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	// Supervisor side
	fns_mon_if.timer  mon
);
	localparam int            PRE_W   = $clog2(MS_CYCLES);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYCLES - 1);

	logic [PRE_W-1:0] pre;
	logic [PRE_W-1:0] next_pre;
	logic [15:0]      ms_left;
	logic [15:0]      next_ms_left;
	logic             armed;
	logic             next_armed;
	logic             expired;
	logic             next_expired;

	// ------------------------------------------------------------------
	// Prescaler and countdown
	// ------------------------------------------------------------------
	// Next state of prescaler and millisecond counter
	always_comb begin
		next_pre     = pre;
		next_ms_left = ms_left;
		next_armed   = armed;
		next_expired = 1'b0;
		// [R24] reload on frame
		if (mon.restart) begin
			next_pre     = '0;
			next_ms_left = mon.limit_ms;
			next_armed   = (mon.limit_ms != 16'h0000);
		end else if (armed) begin
			if (pre == PRE_LAST) begin
				next_pre = '0;
				// [R20] count down time
				if (ms_left == 16'h0001) begin
					next_armed   = 1'b0;
					next_expired = 1'b1;
				end else begin
					next_ms_left = ms_left - 16'h0001;
				end
			end else begin
				next_pre = pre + PRE_W'(1);
			end
		end
	end

	// Timer registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre     <= '0;
			ms_left <= 16'h0000;
			armed   <= 1'b0;
			expired <= 1'b0;
		end else begin
			pre     <= next_pre;
			ms_left <= next_ms_left;
			armed   <= next_armed;
			expired <= next_expired;
		end
	end

	assign mon.expired = expired;
	assign mon.armed   = armed;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	expire_one_ms_a: assert property ( // [R24]
		(armed && !mon.restart && pre == PRE_LAST && ms_left == 16'h0001) |=> (expired && !armed))
		else $error("timer did not expire after last millisecond");
	zero_disables_a: assert property ( // [R20]
		(mon.restart && mon.limit_ms == 16'h0000) |=> (!armed ##1 !expired))
		else $error("zero monitoring time did not disable timer");
endmodule
`default_nettype wire

//--- sim/fns_master_model.sv
// Bus master model issuing register requests and frame marks
`timescale 1ns/1ps
`default_nettype none
module fns_master_model
	import fns_pkg::*;
(
	// Clock and answers
	input  wire logic        sys_clk_i,
	input  wire logic        rsp_valid_i,
	input  wire logic        rsp_error_i,
	input  wire logic [15:0] rsp_rdata_i,
	// Requests
	output logic             req_valid_o,
	output logic             req_write_o,
	output logic [7:0]       req_node_o,
	output logic [15:0]      req_addr_o,
	output logic [15:0]      req_wdata_o,
	output logic             frame_ok_o
);
	// Idle bus at start
	initial begin
		req_valid_o = 1'b0;
		req_write_o = 1'b0;
		req_node_o  = 8'h00;
		req_addr_o  = 16'h0000;
		req_wdata_o = 16'h0000;
		frame_ok_o  = 1'b0;
	end
	// One request pulse, answer taken one cycle later
	task automatic xfer(input logic w, input logic [7:0] n, input logic [15:0] a, d,
		output logic v, output logic e, output logic [15:0] q);
		@(posedge sys_clk_i);
		req_valid_o <= 1'b1;
		req_write_o <= w;
		req_node_o  <= n;
		req_addr_o  <= a;
		// command writes keep upper bits zero
		req_wdata_o <= (a == FNS_CMD_ADDR) ? (d & 16'h0003) : d;
		@(posedge sys_clk_i);
		req_valid_o <= 1'b0;
		req_addr_o  <= ~a; // Released lines toggle
		req_wdata_o <= ~d;
		#1;
		v = rsp_valid_i;
		e = rsp_error_i;
		q = rsp_rdata_i;
	endtask
	// each mark is one whole 8E1 RTU frame
	task automatic frame();
		@(posedge sys_clk_i);
		frame_ok_o <= 1'b1;
		@(posedge sys_clk_i);
		frame_ok_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the fieldbus node supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench
	import fns_pkg::*;
();
	logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, txb = 1'b0, bad = 1'b0;
	logic [3:0]  tens = 4'h1, units = 4'h2, baud = 4'h6, dbits;
	logic [15:0] img = 16'h1234, fbv = 16'h00a5, q, ra, rd, wd, rdat, brate, isl;
	logic        rv, rw, fok, v, e, rspv, rspe, txe, rxe, nval, comm, par, run, swp, fb, flt;
	logic [7:0]  rn, naddr;
	logic [1:0]  stopb;
	int          mismatches = 0, total_checks = 0;

	// Clock
	always #4 sys_clk_i = ~sys_clk_i;

	fns_master_model master (.sys_clk_i, .rsp_valid_i(rspv), .rsp_error_i(rspe),
		.rsp_rdata_i(rdat), .req_valid_o(rv), .req_write_o(rw), .req_node_o(rn),
		.req_addr_o(ra), .req_wdata_o(wd), .frame_ok_o(fok));

	fns_supervisor #(.MS_CYCLES(4)) dut (.sys_clk_i, .rst_n_i, .addr_tens_i(tens),
		.addr_units_i(units), .baud_pos_i(baud), .req_valid_i(rv), .req_write_i(rw),
		.req_node_i(rn), .req_addr_i(ra), .req_wdata_i(wd), .frame_ok_i(fok),
		.rsp_valid_o(rspv), .rsp_error_o(rspe), .rsp_rdata_o(rdat), .tx_busy_i(txb),
		.link_tx_en_o(txe), .link_rx_en_o(rxe), .node_addr_o(naddr), .node_valid_o(nval),
		.baud_rate_o(brate), .comm_enable_o(comm), .frame_data_bits_o(dbits),
		.frame_parity_even_o(par), .frame_stop_bits_o(stopb), .exp_param_bad_i(bad),
		.island_out_i(img), .fallback_val_i(fbv), .island_out_o(isl),
		.int_bus_run_o(run), .word_swap_o(swp), .fallback_o(fb), .fault_present_o(flt));

	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Request to this node with expected answer
	task automatic rq(input logic w, input logic [15:0] a, d, input logic er, input logic [15:0] x);
		master.xfer(w, 8'h0c, a, d, v, e, q);
		chk({15'h0, v}, 16'h0001);
		chk({15'h0, e}, {15'h0, er});
		if (!w) chk(q, x);
	endtask
	// Power cycle with given switches
	task automatic pwr(input logic [3:0] t, u, b);
		@(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		tens <= t;
		units <= u;
		baud <= b;
		repeat (16) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (8) @(posedge sys_clk_i);
	endtask
	// Selector positions 0 to 6
	task automatic t_baud();
		logic [15:0] rates [7];
		rates = '{FNS_BAUD_19200, FNS_BAUD_1200, FNS_BAUD_2400, FNS_BAUD_4800,
			FNS_BAUD_9600, FNS_BAUD_19200, FNS_BAUD_38400};
		for (int p = 0; p < 7; p++) begin
			pwr(4'h1, 4'h2, 4'(p));
			chk(brate, rates[p]);
		end
	endtask
	// Captured settings and late switch moves
	task automatic t_capture();
		chk({8'h0, naddr}, 16'h000c);
		chk({15'h0, nval}, 16'h0001);
		chk({8'h0, dbits, 1'b0, par, stopb}, 16'h0085);
		@(posedge sys_clk_i);
		tens <= 4'h3;
		baud <= 4'h1;
		repeat (6) @(posedge sys_clk_i);
		chk({8'h0, naddr}, 16'h000c);
		chk(brate, FNS_BAUD_38400);
		master.xfer(1'b0, 8'h0d, FNS_CFG_ADDR, 16'h0, v, e, q);
		chk({15'h0, v}, 16'h0000);
		@(posedge sys_clk_i);
		txb <= 1'b1;
		@(posedge sys_clk_i);
		#1;
		chk({14'h0, txe, rxe}, 16'h0002);
		@(posedge sys_clk_i);
		txb <= 1'b0;
		#1;
		chk({14'h0, txe, rxe}, 16'h0001);
	endtask
	// Register defaults, access kinds, halt
	task automatic t_regs();
		rq(0, FNS_TMO_ADDR, 0, 0, 16'h0);
		rq(0, FNS_CFG_ADDR, 0, 0, 16'h0);
		rq(1, FNS_CFG_ADDR, 1, 0, 0);
		chk({15'h0, swp}, 16'h0001);
		rq(1, FNS_CNT_ADDR, 5, 1, 0);
		rq(0, 16'h0100, 0, 1, 0);
		rq(1, FNS_HALT_ADDR, 1, 0, 0);
		chk({img[15:1], run}, img & 16'hfffe);
		chk(isl, 16'h0);
		@(posedge sys_clk_i);
		bad <= 1'b1;
		rq(1, FNS_HALT_ADDR, 0, 0, 0);
		chk({15'h0, run}, 16'h0);
		@(posedge sys_clk_i);
		bad <= 1'b0;
		rq(1, FNS_HALT_ADDR, 0, 0, 0);
		chk(isl, img);
	endtask
	// Manual then automatic fallback exit
	task automatic t_fall();
		rq(1, FNS_CFG_ADDR, 2, 0, 0);
		rq(1, FNS_TMO_ADDR, 1, 0, 0);
		repeat (12) @(posedge sys_clk_i);
		chk(isl, fbv);
		rq(0, FNS_STATUS_ADDR, 0, 0, 16'h0200);
		rq(0, FNS_CMD_ADDR, 0, 0, 16'h0001);
		rq(0, FNS_CNT_ADDR, 0, 0, 16'h0001);
		rq(1, FNS_CMD_ADDR, 3, 0, 0);
		rq(0, FNS_CNT_ADDR, 0, 0, 16'h0000);
		chk({14'h0, fb, flt}, 16'h0003);
		rq(1, FNS_CMD_ADDR, 0, 0, 0);
		chk({14'h0, fb, flt}, 16'h0000);
		rq(1, FNS_TMO_ADDR, 0, 0, 0);
		rq(1, FNS_CFG_ADDR, 0, 0, 0);
		rq(1, FNS_TMO_ADDR, 1, 0, 0);
		repeat (12) @(posedge sys_clk_i);
		rq(0, FNS_CNT_ADDR, 0, 0, 16'h0001);
		chk({14'h0, fb, flt}, 16'h0000);
		rq(1, FNS_TMO_ADDR, 2, 0, 0);
		repeat (10) master.frame();
		chk({15'h0, fb}, 16'h0);
		rq(1, FNS_TMO_ADDR, 0, 0, 0);
	endtask
	// Invalid addresses stay silent
	task automatic t_dead();
		pwr(4'h0, 4'h0, 4'h6);
		master.xfer(1'b0, 8'h00, FNS_CFG_ADDR, 16'h0, v, e, q);
		chk({14'h0, v, comm}, 16'h0);
		pwr(4'hc, 4'h8, 4'h6);
		master.xfer(1'b0, 8'h80, FNS_CFG_ADDR, 16'h0, v, e, q);
		chk({14'h0, v, nval}, 16'h0);
	endtask
	// Verdict and end of run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#500000;
		mismatches++;
		end_of_test();
	end
	// Main sequence
	initial begin
		t_baud();
		t_capture();
		t_regs();
		t_fall();
		t_dead();
		end_of_test();
	end
endmodule
`default_nettype wire
